// >>> src/lgr_dev.sv
// device end: rom command layer, scratchpad, memory map and access checks
// assumes the master times the slots and waits two cycles before sampling
`default_nettype none
module lgr_dev #(
    parameter logic [7:0] FAMILY = 8'h5A,          // arbitrary value
    parameter logic [47:0] SERIAL = 48'h0000_1234_5678 // arbitrary value
) (
    input wire logic clock,
    input wire logic srst,
    lgr_link_if.dev lk,
    input wire logic batt_ok,
    input wire logic mission_on,
    input wire logic log_we,
    input wire logic [12:0] log_wa,
    input wire logic [7:0] log_wd,
    output logic od_mode,
    output logic selected
);
    localparam logic [lgr_pkg::ID_BITS-1:0] ID =
        {lgr_pkg::crc8_calc({SERIAL, FAMILY}), SERIAL, FAMILY};

    typedef enum logic [3:0] {
        S_ROM, S_IDTX, S_MATCH, S_FUNC, S_WADR, S_WDAT, S_RADR, S_RDAT, S_RSP, S_CPY, S_IDLE
    } lgr_dst_e;

    typedef struct packed {
        lgr_dst_e st;
        logic od;
        logic sel;
        logic mm;
        logic adr_hi;
        logic rd_to;
        logic [2:0] bitc;
        logic [5:0] idx;
        logic [7:0] sh;
        logic [13:0] ta;
        logic [4:0] so;
        logic [4:0] es;
        logic [4:0] ca;
        logic rdb;
    } lgr_dev_s;

    lgr_dev_s r, n;
    logic [7:0] ram [lgr_pkg::RAM_BYTES];
    logic [7:0] logm [lgr_pkg::LOG_BYTES];
    logic [7:0] scr [lgr_pkg::PAGE_BYTES];
    logic sp_we, ram_we, wr_slot, rd_slot, done;
    logic [7:0] rx, rd_byte, tx_byte;
    logic [13:0] ram_wa, cp_addr;

    // ==========================================================
    // access checks
    function automatic logic is_pw(input logic [13:0] a);
        is_pw = a >= lgr_pkg::PW_LO && a <= lgr_pkg::PW_HI;
    endfunction

    function automatic logic wr_ok(input logic [13:0] a, input logic mis);
        logic [8:0] pg;
        logic ro;
        pg = a[13:lgr_pkg::PAGE_SHIFT];
        ro = (a >= lgr_pkg::RO_A_LO && a <= lgr_pkg::RO_A_HI)
            || (a >= lgr_pkg::RO_B_LO && a <= lgr_pkg::RO_B_HI)
            || (a >= lgr_pkg::RO_C_LO && a <= lgr_pkg::RO_C_HI);
        if (a >= lgr_pkg::RAM_END) begin
            wr_ok = 1'b0;
        end else if (pg >= lgr_pkg::REG_PG_FIRST && pg <= lgr_pkg::REG_PG_LAST) begin
            wr_ok = !mis && !ro;
        end else begin
            wr_ok = 1'b1;
        end
    endfunction

    // ==========================================================
    // linear read path
    always_comb begin
        rd_byte = 8'h00;
        if (r.ta < lgr_pkg::RAM_END) begin
            if (!is_pw(r.ta)) begin
                rd_byte = ram[r.ta[9:0]];
            end
        end else if (r.ta >= lgr_pkg::LOG_BASE && r.ta < lgr_pkg::LOG_END) begin
            rd_byte = logm[13'(r.ta - lgr_pkg::LOG_BASE)];
        end
        tx_byte = (r.st == S_RSP) ? scr[r.ta[4:0]] : rd_byte;
    end

    // ==========================================================
    // protocol
    always_comb begin
        n = r;
        wr_slot = lk.slot_stb && lk.slot_wr;
        rd_slot = lk.slot_stb && !lk.slot_wr;
        rx = {lk.slot_bit, r.sh[7:1]};
        done = wr_slot && r.bitc == 3'h7;
        sp_we = 1'b0;
        cp_addr = {r.ta[13:5], r.ca};
        ram_wa = cp_addr;
        ram_we = 1'b0;
        if (lk.bus_rst) begin
            n.st = S_ROM;
            n.od = 1'b0;
            n.bitc = 3'h0;
            n.rdb = 1'b1;
        end else begin
            if (wr_slot) begin
                n.sh = rx;
                n.bitc = r.bitc + 3'h1;
            end
            if (rd_slot && (r.st == S_RDAT || r.st == S_RSP)) begin
                n.rdb = tx_byte[r.bitc];
                n.bitc = r.bitc + 3'h1;
                if (r.bitc == 3'h7) begin
                    n.ta = (r.st == S_RSP) ? {r.ta[13:5], r.ta[4:0] + 5'h01} : r.ta + 14'h0001;
                end
            end
            case (r.st)
                S_ROM: begin
                    if (done) begin
                        n.idx = 6'h00;
                        n.mm = 1'b0;
                        case (rx)
                            lgr_pkg::ROM_READ: n.st = S_IDTX;
                            lgr_pkg::ROM_MATCH: n.st = S_MATCH;
                            lgr_pkg::ROM_SKIP: begin
                                n.sel = 1'b0;
                                n.st = S_FUNC;
                            end
                            lgr_pkg::ROM_OD_SKIP: begin
                                n.od = 1'b1;
                                n.sel = 1'b0;
                                n.st = S_FUNC;
                            end
                            lgr_pkg::ROM_OD_MATCH: begin
                                n.od = 1'b1;
                                n.st = S_MATCH;
                            end
                            lgr_pkg::ROM_RESUME: n.st = r.sel ? S_FUNC : S_IDLE;
                            default: n.st = S_IDLE;
                        endcase
                    end
                end
                S_IDTX: begin
                    if (rd_slot) begin
                        n.rdb = ID[r.idx];
                        n.idx = r.idx + 6'h01;
                        if (r.idx == 6'h3F) begin
                            n.st = S_FUNC;
                        end
                    end
                end
                S_MATCH: begin
                    if (wr_slot) begin
                        n.idx = r.idx + 6'h01;
                        if (lk.slot_bit != ID[r.idx]) begin
                            n.mm = 1'b1;
                        end
                        if (r.idx == 6'h3F) begin
                            n.sel = !n.mm;
                            n.st = n.mm ? S_IDLE : S_FUNC;
                        end
                    end
                end
                S_FUNC: begin
                    if (done) begin
                        n.adr_hi = 1'b0;
                        if (!batt_ok) begin
                            n.st = S_IDLE;
                        end else begin
                            case (rx)
                                lgr_pkg::FN_WR_SP: begin
                                    n.rd_to = 1'b0;
                                    n.st = S_WADR;
                                end
                                lgr_pkg::FN_RD_MEM: begin
                                    n.rd_to = 1'b1;
                                    n.st = S_WADR;
                                end
                                lgr_pkg::FN_RD_SP: begin
                                    n.ta = {r.ta[13:5], r.so};
                                    n.st = S_RSP;
                                end
                                lgr_pkg::FN_CP_SP: begin
                                    n.ca = r.so;
                                    n.st = S_CPY;
                                end
                                default: n.st = S_IDLE;
                            endcase
                        end
                    end
                end
                S_WADR: begin
                    if (done) begin
                        if (!r.adr_hi) begin
                            n.ta[7:0] = rx;
                            n.adr_hi = 1'b1;
                        end else begin
                            n.ta[13:8] = rx[5:0];
                            n.so = r.ta[4:0];
                            n.es = r.ta[4:0];
                            n.st = r.rd_to ? S_RDAT : S_WDAT;
                        end
                    end
                end
                S_WDAT: begin
                    if (done) begin
                        sp_we = 1'b1;
                        n.es = r.ta[4:0];
                        n.ta[4:0] = r.ta[4:0] + 5'h01;
                    end
                end
                S_CPY: begin
                    ram_we = wr_ok(cp_addr, mission_on);
                    n.ca = r.ca + 5'h01;
                    if (r.ca == r.es) begin
                        n.st = S_IDLE;
                    end
                end
                S_RDAT, S_RSP, S_IDLE: begin
                end
                default: n.st = S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // state and memories
    always_ff @(posedge clock) begin
        if (srst) begin
            r <= '0;
            r.st <= S_IDLE;
            r.rdb <= 1'b1;
        end else begin
            r <= n;
        end
    end

    always_ff @(posedge clock) begin
        if (sp_we) begin
            scr[r.ta[4:0]] <= rx;
        end
        if (ram_we) begin
            ram[ram_wa[9:0]] <= scr[r.ca];
        end
        if (log_we) begin
            logm[log_wa] <= log_wd;
        end
    end

    assign lk.rd_bit = r.rdb;
    assign od_mode = r.od;
    assign selected = r.sel;
endmodule // lgr_dev
`default_nettype wire

// >>> src/lgr_pkg.sv
// constants, command codes and crc helpers shared by both link ends
// assumes one 50 MHz clock; the link is abstracted to one-cycle bit slots
`default_nettype none
package lgr_pkg;
    // ==========================================================
    // timing
    localparam int CLK_NS = 20;
    localparam int SLOT_STD_NS = 65000;
    localparam int SLOT_OD_NS = 9500;
    localparam int SLOT_STD_CYC = (SLOT_STD_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOT_OD_CYC = (SLOT_OD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DIV_W = 12;

    // ==========================================================
    // identity layout
    localparam int FAM_BITS = 8;
    localparam int SER_BITS = 48;
    localparam int CRC_BITS = 8;
    localparam int ID_BITS = FAM_BITS + SER_BITS + CRC_BITS;
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

    // ==========================================================
    // memory map
    localparam int ADDR_W = 14;
    localparam int PAGE_SHIFT = 5;
    localparam int PAGE_BYTES = 32;
    localparam logic [8:0] REG_PG_FIRST = 9'h010;
    localparam logic [8:0] REG_PG_LAST = 9'h011;
    localparam int RAM_PAGES = 20;
    localparam int RAM_BYTES = RAM_PAGES * PAGE_BYTES;
    localparam logic [ADDR_W-1:0] RAM_END = 14'h0280;
    localparam logic [ADDR_W-1:0] LOG_BASE = 14'h1000;
    localparam int LOG_BYTES = 8192;
    localparam logic [ADDR_W-1:0] LOG_END = 14'h3000;
    localparam logic [ADDR_W-1:0] RO_A_LO = 14'h020C;
    localparam logic [ADDR_W-1:0] RO_A_HI = 14'h020F;
    localparam logic [ADDR_W-1:0] RO_B_LO = 14'h0214;
    localparam logic [ADDR_W-1:0] RO_B_HI = 14'h0215;
    localparam logic [ADDR_W-1:0] RO_C_LO = 14'h0219;
    localparam logic [ADDR_W-1:0] RO_C_HI = 14'h0226;
    localparam logic [ADDR_W-1:0] PW_LO = 14'h0228;
    localparam logic [ADDR_W-1:0] PW_HI = 14'h0237;

    // ==========================================================
    // command codes
    localparam logic [7:0] ROM_READ = 8'hA1;
    localparam logic [7:0] ROM_MATCH = 8'hA2;
    localparam logic [7:0] ROM_SEARCH = 8'hA3;
    localparam logic [7:0] ROM_CSEARCH = 8'hA4;
    localparam logic [7:0] ROM_SKIP = 8'hA5;
    localparam logic [7:0] ROM_OD_SKIP = 8'hA6;
    localparam logic [7:0] ROM_OD_MATCH = 8'hA7;
    localparam logic [7:0] ROM_RESUME = 8'hA8;
    localparam logic [7:0] FN_WR_SP = 8'hB1;
    localparam logic [7:0] FN_RD_SP = 8'hB2;
    localparam logic [7:0] FN_CP_SP = 8'hB3;
    localparam logic [7:0] FN_RD_MEM = 8'hB4;

    typedef enum logic [1:0] {HC_RESET, HC_WRITE, HC_READ} lgr_hcmd_e;

    // ==========================================================
    // crc, lsb first shift register with xor feedback
    function automatic logic [7:0] crc8_bit(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc8_bit = (c >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
    endfunction

    function automatic logic [7:0] crc8_calc(input logic [FAM_BITS+SER_BITS-1:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < FAM_BITS + SER_BITS; i++) begin
            c = crc8_bit(c, d[i]);
        end
        crc8_calc = c;
    endfunction
endpackage
`default_nettype wire

// >>> src/lgr_link_if.sv
// abstract single-lead link: master-timed bit slots, one cycle each
// assumes both ends share clock; the wire level itself is not modelled
`default_nettype none
interface lgr_link_if (
    input wire logic clock
);
    logic bus_rst;
    logic slot_stb;
    logic slot_wr;
    logic slot_bit;
    logic rd_bit;

    modport dev (input bus_rst, input slot_stb, input slot_wr, input slot_bit, output rd_bit);
    modport host (output bus_rst, output slot_stb, output slot_wr, output slot_bit, input rd_bit);
endinterface
`default_nettype wire

// >>> src/lgr_host.sv
// master end: slot timing, lsb-first bytes, identity crc check, rx buffer
// assumes the user issues rom and function bytes in legal order
`default_nettype none
module lgr_host #(
    parameter int STD_CYC = lgr_pkg::SLOT_STD_CYC,
    parameter int OD_CYC = lgr_pkg::SLOT_OD_CYC,
    parameter int DEPTH = 2,
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic srst,
    lgr_link_if.host lk,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire lgr_pkg::lgr_hcmd_e cmd_kind,
    input wire logic [7:0] cmd_byte,
    output logic rx_valid,
    output logic [W-1:0] rx_data,
    input wire logic rx_ready,
    output logic crc_zero
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef enum logic [2:0] {H_IDLE, H_RST, H_WR, H_RD, H_RW, H_CAP} lgr_hst_e;

    typedef struct packed {
        lgr_hst_e st;
        logic [lgr_pkg::DIV_W-1:0] cnt;
        logic od;
        logic first;
        logic [7:0] ob;
        logic [7:0] sh;
        logic [2:0] bitc;
        logic [7:0] crc;
        logic rst_o;
        logic stb;
        logic wr;
        logic bt;
        logic [DEPTH-1:0][W-1:0] fq;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] fc;
    } lgr_host_s;

    lgr_host_s r, n;
    logic tick, push, pop, full;

    always_comb begin
        n = r;
        n.rst_o = 1'b0;
        n.stb = 1'b0;
        tick = r.cnt == '0;
        full = r.fc == CW'(DEPTH);
        push = 1'b0;
        pop = rx_ready && r.fc != '0;
        n.cnt = tick ? lgr_pkg::DIV_W'((r.od ? OD_CYC : STD_CYC) - 1) : r.cnt - 1'b1;
        case (r.st)
            H_IDLE: begin
                if (cmd_valid) begin
                    n.ob = cmd_byte;
                    n.sh = cmd_byte;
                    n.bitc = 3'h0;
                    case (cmd_kind)
                        lgr_pkg::HC_RESET: n.st = H_RST;
                        lgr_pkg::HC_WRITE: n.st = H_WR;
                        default: n.st = H_RD;
                    endcase
                end
            end
            H_RST: begin
                if (tick) begin
                    n.rst_o = 1'b1;
                    n.od = 1'b0;
                    n.first = 1'b1;
                    n.crc = 8'h00;
                    n.st = H_IDLE;
                end
            end
            H_WR: begin
                if (tick) begin
                    n.stb = 1'b1;
                    n.wr = 1'b1;
                    n.bt = r.sh[0];
                    n.sh = r.sh >> 1;
                    n.bitc = r.bitc + 3'h1;
                    if (r.bitc == 3'h7) begin
                        if (r.first && (r.ob == lgr_pkg::ROM_OD_SKIP
                            || r.ob == lgr_pkg::ROM_OD_MATCH)) begin
                            n.od = 1'b1;
                        end
                        n.first = 1'b0;
                        n.st = H_IDLE;
                    end
                end
            end
            H_RD: begin
                // no slot while the buffer is full: the device cannot stall
                if (tick && !full) begin
                    n.stb = 1'b1;
                    n.wr = 1'b0;
                    n.st = H_RW;
                end
            end
            H_RW: n.st = H_CAP;
            H_CAP: begin
                n.sh = {lk.rd_bit, r.sh[7:1]};
                n.crc = lgr_pkg::crc8_bit(r.crc, lk.rd_bit);
                n.bitc = r.bitc + 3'h1;
                if (r.bitc == 3'h7) begin
                    push = 1'b1;
                    n.st = H_IDLE;
                end else begin
                    n.st = H_RD;
                end
            end
            default: n.st = H_IDLE;
        endcase
        if (push) begin
            n.fq[r.wp] = {lk.rd_bit, r.sh[7:1]};
            n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
        end
        n.fc = r.fc + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            r <= '0;
            r.st <= H_IDLE;
        end else begin
            r <= n;
        end
    end

    assign cmd_ready = r.st == H_IDLE;
    assign rx_valid = r.fc != '0;
    assign rx_data = r.fq[r.rp];
    assign crc_zero = r.crc == 8'h00;
    assign lk.bus_rst = r.rst_o;
    assign lk.slot_stb = r.stb;
    assign lk.slot_wr = r.wr;
    assign lk.slot_bit = r.bt;
endmodule // lgr_host
`default_nettype wire

// >>> tb/lgr_link_monitor.sv
// checker on the slot signals between the host and device ends
// assumes one shared clock; the testbench instantiates it beside the link
`default_nettype none
module lgr_link_monitor (
    input wire logic clock,
    input wire logic srst,
    input wire logic bus_rst,
    input wire logic slot_stb,
    input wire logic slot_wr,
    input wire logic slot_bit,
    input wire logic rd_bit
);
    // ==========================================
    // helper state, cleared by every bus reset
    logic fresh_r;
    logic idrd_r;
    logic [3:0] wcnt_r;
    logic [7:0] wsh_r;
    logic [6:0] rcnt_r;
    logic [7:0] crc_r;
    logic [1:0] rpipe_r;

    always_ff @(posedge clock) begin
        if (srst || bus_rst) begin
            fresh_r <= 1'b1;
            idrd_r <= 1'b0;
            wcnt_r <= 4'h0;
            wsh_r <= 8'h00;
            rcnt_r <= 7'h00;
            crc_r <= 8'h00;
            rpipe_r <= 2'h0;
        end else begin
            // host samples two cycles after a read strobe
            rpipe_r <= {rpipe_r[0], slot_stb && !slot_wr};
            if (slot_stb) begin
                fresh_r <= 1'b0;
            end
            if (slot_stb && slot_wr && wcnt_r < 4'h8) begin
                wsh_r <= {slot_bit, wsh_r[7:1]};
                wcnt_r <= wcnt_r + 4'h1;
            end
            if (wcnt_r == 4'h8 && wsh_r == lgr_pkg::ROM_READ) begin
                idrd_r <= 1'b1;
            end
            if (idrd_r && rpipe_r[1] && rcnt_r < 7'h40) begin
                // reflected x8+x5+x4+1
                crc_r <= (crc_r >> 1) ^ ((crc_r[0] ^ rd_bit) ? 8'h8C : 8'h00);
                rcnt_r <= rcnt_r + 7'h01;
            end
        end
    end

    // ==========================================
    // assertions
    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (srst);

    reset_pulse_a: assert property (bus_rst |=> !bus_rst)
        else $error("bus reset longer than one cycle");
    slot_pulse_a: assert property (slot_stb |=> !slot_stb)
        else $error("slot strobe longer than one cycle");
    reset_gap_a: assert property (bus_rst |-> !slot_stb ##1 !slot_stb)
        else $error("slot too close to bus reset");
    reset_idle_a: assert property ($fell(srst) |-> rd_bit && !slot_stb && !bus_rst)
        else $error("link not idle after reset");
    rd_hold_a: assert property (!$past(slot_stb) && !$past(bus_rst) |-> $stable(rd_bit))
        else $error("read bit changed outside a slot");
    first_write_a: assert property (fresh_r && slot_stb |-> slot_wr)
        else $error("read slot before rom command");
    rom_first_a: assert property (wcnt_r == 4'h8 |-> wsh_r[7:4] == 4'hA)
        else $error("first byte is not a rom command");
    id_crc_a: assert property (idrd_r && rcnt_r == 7'h40 |-> crc_r == 8'h00)
        else $error("identity crc residue not zero");
endmodule // lgr_link_monitor
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench: host and device ends joined over the link interface
// assumes short slot counts; inputs change on the falling clock edge
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] FAM = 8'h3C; // arbitrary value
    localparam logic [47:0] SER = 48'h0102_0304_0506; // arbitrary value
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic batt_ok = 1'b1;
    logic mission_on = 1'b0;
    logic log_we = 1'b0;
    logic [12:0] log_wa = 13'h0000;
    logic [7:0] log_wd = 8'h00;
    logic [7:0] cmd_byte = 8'h00;
    lgr_pkg::lgr_hcmd_e cmd_kind = lgr_pkg::HC_RESET;
    logic cmd_ready, rx_valid, crc_zero, od_mode, selected;
    logic [7:0] rx_data;
    logic [63:0] id;
    int err_count = 0;
    int checks_done = 0;

    lgr_link_if lgr_link_if_i (.clock(clock));
    lgr_host #(.STD_CYC(4), .OD_CYC(2)) lgr_host_i (.clock(clock), .srst(srst),
        .lk(lgr_link_if_i.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_kind(cmd_kind), .cmd_byte(cmd_byte), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .crc_zero(crc_zero));
    lgr_dev #(.FAMILY(FAM), .SERIAL(SER)) lgr_dev_i (.clock(clock), .srst(srst),
        .lk(lgr_link_if_i.dev), .batt_ok(batt_ok), .mission_on(mission_on), .log_we(log_we),
        .log_wa(log_wa), .log_wd(log_wd), .od_mode(od_mode), .selected(selected));
    lgr_link_monitor lgr_link_monitor_i (.clock(clock), .srst(srst),
        .bus_rst(lgr_link_if_i.bus_rst), .slot_stb(lgr_link_if_i.slot_stb),
        .slot_wr(lgr_link_if_i.slot_wr), .slot_bit(lgr_link_if_i.slot_bit),
        .rd_bit(lgr_link_if_i.rd_bit));

    initial begin
        forever #10 clock = ~clock;
    end

    // ==========================================
    // shared tasks
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic idle;
        for (int n = 0; n < 2000 && cmd_ready !== 1'b1; n++) @(negedge clock);
    endtask

    task automatic send(lgr_pkg::lgr_hcmd_e k, logic [7:0] b);
        idle;
        cmd_kind = k;
        cmd_byte = b;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
    endtask

    task automatic pop(string what, logic [7:0] exp);
        for (int n = 0; n < 2000 && rx_valid !== 1'b1; n++) @(negedge clock);
        check(what, exp, rx_data);
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
    endtask

    task automatic get(string what, logic [7:0] exp);
        send(lgr_pkg::HC_READ, 8'h00);
        pop(what, exp);
    endtask

    task automatic rom(logic [7:0] b);
        send(lgr_pkg::HC_RESET, 8'h00);
        send(lgr_pkg::HC_WRITE, b);
    endtask

    task automatic fn_addr(logic [7:0] f, logic [13:0] a);
        rom(lgr_pkg::ROM_SKIP);
        send(lgr_pkg::HC_WRITE, f);
        send(lgr_pkg::HC_WRITE, a[7:0]);
        send(lgr_pkg::HC_WRITE, {2'b00, a[13:8]});
    endtask

    task automatic wr_page(logic [13:0] a, logic [7:0] d0);
        fn_addr(lgr_pkg::FN_WR_SP, a);
        // whole pages, so a copy always covers all 32 scratch offsets
        for (int i = 0; i < lgr_pkg::PAGE_BYTES; i++) begin
            send(lgr_pkg::HC_WRITE, d0 + 8'(i));
        end
        rom(lgr_pkg::ROM_SKIP);
        send(lgr_pkg::HC_WRITE, lgr_pkg::FN_CP_SP);
        idle;
        repeat (40) @(negedge clock);
    endtask

    task automatic rd_page(string what, logic [13:0] a, logic [7:0] e0, logic [7:0] step);
        fn_addr(lgr_pkg::FN_RD_MEM, a);
        for (int i = 0; i < 4; i++) get(what, e0 + step * 8'(i));
    endtask

    // ==========================================
    // scenarios
    task automatic s_identity;
        logic [7:0] c;
        c = 8'h00;
        id = {8'h00, SER, FAM};
        for (int i = 0; i < 56; i++) c = (c >> 1) ^ ((c[0] ^ id[i]) ? 8'h8C : 8'h00);
        id[63:56] = c;
        batt_ok = 1'b0;
        rom(lgr_pkg::ROM_READ);
        for (int i = 0; i < 8; i++) get("id byte", id[8*i +: 8]);
        check("crc zero", 8'h01, {7'h00, crc_zero});
        batt_ok = 1'b1;
        rom(lgr_pkg::ROM_MATCH);
        for (int i = 0; i < 8; i++) send(lgr_pkg::HC_WRITE, id[8*i +: 8]);
        idle;
        repeat (3) @(negedge clock);
        check("selected", 8'h01, {7'h00, selected});
    endtask

    task automatic s_memory;
        mission_on = 1'b1;
        wr_page(14'h0020, 8'h10);
        rd_page("sram", 14'h0020, 8'h10, 8'h01);
        mission_on = 1'b0;
        wr_page(14'h0210, 8'h20);
        mission_on = 1'b1;
        wr_page(14'h0210, 8'h30);
        rd_page("register", 14'h0210, 8'h20, 8'h01);
        mission_on = 1'b0;
        wr_page(14'h0228, 8'h40);
        rd_page("password", 14'h0228, 8'h00, 8'h00);
        wr_page(14'h0400, 8'h50);
        rd_page("reserved", 14'h0400, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            log_we = 1'b1;
            log_wa = 13'(i);
            log_wd = 8'hC0 + 8'(i);
            @(negedge clock);
        end
        log_we = 1'b0;
        wr_page(14'h1000, 8'h60);
        rd_page("log", 14'h1000, 8'hC0, 8'h01);
    endtask

    task automatic s_stall;
        fn_addr(lgr_pkg::FN_RD_MEM, 14'h0020);
        for (int i = 0; i < 3; i++) send(lgr_pkg::HC_READ, 8'h00);
        repeat (60) @(negedge clock);
        check("stalled", 8'h00, {7'h00, cmd_ready});
        check("buffered", 8'h01, {7'h00, rx_valid});
        for (int i = 0; i < 3; i++) pop("drained", 8'h10 + 8'(i));
    endtask

    task automatic s_overdrive;
        rom(lgr_pkg::ROM_OD_SKIP);
        repeat (12) @(negedge clock);
        check("od early", 8'h00, {7'h00, od_mode});
        idle;
        repeat (2) @(negedge clock);
        check("od on", 8'h01, {7'h00, od_mode});
        send(lgr_pkg::HC_WRITE, lgr_pkg::FN_RD_MEM);
        send(lgr_pkg::HC_WRITE, 8'h21);
        send(lgr_pkg::HC_WRITE, 8'h00);
        get("od read", 8'h11);
        send(lgr_pkg::HC_RESET, 8'h00);
        idle;
        repeat (2) @(negedge clock);
        check("od off", 8'h00, {7'h00, od_mode});
        rom(lgr_pkg::ROM_OD_MATCH);
        for (int i = 0; i < 8; i++) send(lgr_pkg::HC_WRITE, id[8*i +: 8]);
        idle;
        repeat (3) @(negedge clock);
        check("od match", 8'h03, {6'h00, od_mode, selected});
        // resume relies on the match above; scratch offset is still 1 from address 0021
        rom(lgr_pkg::ROM_RESUME);
        send(lgr_pkg::HC_WRITE, lgr_pkg::FN_RD_SP);
        get("scratch", 8'h61);
        batt_ok = 1'b0;
        fn_addr(lgr_pkg::FN_RD_MEM, 14'h0020);
        get("no battery", 8'hFF);
        batt_ok = 1'b1;
    endtask

    task automatic complete_run;
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clock);
        srst = 1'b0;
        s_identity;
        s_memory;
        s_stall;
        s_overdrive;
        complete_run;
    end

    // the full sequence needs well under a third of this span
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        complete_run;
    end
endmodule // testbench
`default_nettype wire
